// ### hdl/interference_table_codec.sv
// codec for one interference-table group, framer and parser, behind Wishbone
// assumes a classic Wishbone master on the same clock; octet stream pins are
// same-domain handshaked with valid/ready
//
// Behaviour
// - first group octet is the affected node count m
// - m one-octet affected node identifiers follow from octet 1
// - interferer list follows directly after the node identifiers
// - scope bitmap follows interferer list; bit 0 means all nodes share it
// - scope bit 1 means all interfering domain nodes interfere; list estimated; framer sends bit 1 equal to bit 0
// - transmit zero in scope bits 2-7; ignore them on receive
// - interferer list starts with domain count k
// - exactly k per-domain entries follow, first to last
// - entry starts with 24-bit domain identifier then one-octet ordinal
// - entry octet 4 is node count n, then n identifiers
// - group preceded by 16-bit length prefix in octets
module interference_table_codec
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic rxValid,
    input wire logic [7:0] rxOctet,
    output logic rxReady,
    output logic txValid,
    output logic [7:0] txOctet,
    input wire logic txReady
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wrReq;
    logic rdReq;
    logic hitCtrl;
    logic hitStatus;
    logic hitTx;
    logic hitRx;
    logic hitInfo;
    logic hitScope;
    logic mapped;
    logic [31:0] next_rdata;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wrReq = req && wb_we_i && wb_sel_i[0];
    assign rdReq = req && !wb_we_i;
    assign hitCtrl = wb_adr_i[7:0] == itab_pkg::CTRL_ADDR;
    assign hitStatus = wb_adr_i[7:0] == itab_pkg::STATUS_ADDR;
    assign hitTx = wb_adr_i[7:0] == itab_pkg::TXDATA_ADDR;
    assign hitRx = wb_adr_i[7:0] == itab_pkg::RXDATA_ADDR;
    assign hitInfo = wb_adr_i[7:0] == itab_pkg::RXINFO_ADDR;
    assign hitScope = wb_adr_i[7:0] == itab_pkg::TXSCOPE_ADDR;
    assign mapped = (wb_adr_i[31:8] == 24'h000000)
                    && (hitCtrl || hitStatus || hitTx || hitRx || hitInfo || hitScope);

    // ------------------------------------------------------------
    // framer: software writes octets, scope octet is forced clean
    // ------------------------------------------------------------
    itab_pkg::octet_s txIn;
    itab_pkg::tag_s txTag;
    logic txStart;
    logic txDone;
    logic txLenError;
    logic txBusy;
    logic [7:0] txScopeReg;
    logic [7:0] txPick;
    logic txAccept;
    logic txFull;

    assign txStart = wrReq && hitCtrl && wb_dat_i[itab_pkg::CTRL_TXSTART_BIT];
    assign txFull = txValid && !txReady;
    assign txAccept = wrReq && hitTx && !txFull && txTag.field != itab_pkg::P_SCOPE;
    // scope octet: bits 2-7 zero, bits 0 and 1 mirror one setting
    assign txPick = (txTag.field == itab_pkg::P_SCOPE)
                    ? (txScopeReg & itab_pkg::SCOPE_USED_MASK)
                    : wb_dat_i[7:0];
    assign txIn = '{valid: txAccept || (txBusy && txTag.field == itab_pkg::P_SCOPE && !txFull),
                    octet: txPick};

    octet_walker txWalk
    (
        .clock(clock),
        .rst(rst),
        .start(txStart),
        .inOctet(txIn),
        .tag(txTag),
        .declaredLen(),
        .bodyCount(),
        .done(txDone),
        .lenError(txLenError)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            txValid <= 1'b0;
            txOctet <= itab_pkg::OCTET_RESET;
            txBusy <= 1'b0;
            txScopeReg <= itab_pkg::OCTET_RESET;
        end
        else
        begin
            if (wrReq && hitScope)
            begin
                // one setting drives both scope bits
                txScopeReg <= {6'h00, wb_dat_i[0], wb_dat_i[0]};
            end
            if (txStart)
            begin
                txBusy <= 1'b1;
            end
            else if (txDone)
            begin
                txBusy <= 1'b0;
            end
            if (txIn.valid)
            begin
                txValid <= 1'b1;
                txOctet <= txIn.octet;
            end
            else if (txReady)
            begin
                txValid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // parser: octets from the peer, read out by software
    // ------------------------------------------------------------
    itab_pkg::octet_s rxIn;
    itab_pkg::tag_s rxTag;
    logic rxStart;
    logic rxDone;
    logic rxLenError;
    logic [15:0] rxDeclared;
    logic [15:0] rxCount;
    logic rxHeld;
    logic [7:0] rxData;
    logic [3:0] rxField;
    logic [7:0] rxScope;
    logic rxOverrun;

    assign rxStart = wrReq && hitCtrl && wb_dat_i[itab_pkg::CTRL_RXSTART_BIT];
    assign rxIn = '{valid: rxValid && rxReady, octet: rxOctet};

    octet_walker rxWalk
    (
        .clock(clock),
        .rst(rst),
        .start(rxStart),
        .inOctet(rxIn),
        .tag(rxTag),
        .declaredLen(rxDeclared),
        .bodyCount(rxCount),
        .done(rxDone),
        .lenError(rxLenError)
    );

    always_ff @(posedge clock)
    begin
        if (rst || rxStart)
        begin
            rxReady <= 1'b0;
            rxHeld <= 1'b0;
            rxData <= itab_pkg::OCTET_RESET;
            rxField <= 4'h0;
            rxScope <= itab_pkg::OCTET_RESET;
            rxOverrun <= 1'b0;
        end
        else
        begin
            // stall the peer while an octet waits for software
            rxReady <= !rxHeld && !rxIn.valid && !rxDone;
            if (rxIn.valid)
            begin
                rxHeld <= 1'b1;
                rxData <= rxOctet;
                rxField <= 4'(rxTag.headIdx) | {rxTag.field == itab_pkg::P_SCOPE, 3'h0};
                if (rxTag.field == itab_pkg::P_SCOPE)
                begin
                    rxScope <= rxOctet & itab_pkg::SCOPE_USED_MASK;
                end
            end
            else if (rdReq && hitRx)
            begin
                rxHeld <= 1'b0;
            end
            if (rxIn.valid && rxTag.field == itab_pkg::P_SCOPE
                && rxOctet[itab_pkg::SCOPE_ALL_NODES_BIT] != rxOctet[itab_pkg::SCOPE_ESTIMATE_BIT])
            begin
                rxOverrun <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------
    assign next_rdata = hitStatus ? {16'h0000, 8'h00, rxOverrun, rxLenError, rxDone, rxHeld,
                                     txLenError, txDone, txBusy, txFull}
                      : hitRx ? {20'h00000, rxField, rxData}
                      : hitInfo ? {rxDeclared, rxCount}
                      : hitScope ? {24'h000000, rxScope}
                      : itab_pkg::BUS_ERR_DATA;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= itab_pkg::BUS_ERR_DATA;
        end
        else
        begin
            wb_ack_o <= req && mapped;
            wb_err_o <= req && !mapped;
            wb_dat_o <= (rdReq && mapped) ? next_rdata : itab_pkg::BUS_ERR_DATA;
        end
    end
endmodule

// ### inc/itab_pkg.sv
// package for the interference-table group codec
// assumes a single 200 MHz clock domain and a synchronous reset
package itab_pkg;

    // ------------------------------------------------------------
    // register map (32-bit words, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] TXDATA_ADDR = 8'h08;
    localparam logic [7:0] RXDATA_ADDR = 8'h0C;
    localparam logic [7:0] RXINFO_ADDR = 8'h10;
    localparam logic [7:0] TXSCOPE_ADDR = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TXSTART_BIT = 0;
    localparam int CTRL_RXSTART_BIT = 1;
    localparam int SCOPE_ALL_NODES_BIT = 0;
    localparam int SCOPE_ESTIMATE_BIT = 1;
    localparam logic [7:0] SCOPE_USED_MASK = 8'h03;
    localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
    localparam logic [7:0] OCTET_RESET = 8'h00;
    localparam logic [15:0] LEN_RESET = 16'h0000;
    localparam int ENTRY_HEAD_OCTETS = 5;

    // ------------------------------------------------------------
    // parser / framer structural position
    // ------------------------------------------------------------
    typedef enum logic [8:0]
    {
        P_LENHI = 9'h001,
        P_LENLO = 9'h002,
        P_NODECNT = 9'h004,
        P_NODES = 9'h008,
        P_DOMCNT = 9'h010,
        P_DOMHEAD = 9'h020,
        P_IFNODES = 9'h040,
        P_SCOPE = 9'h080,
        P_DONE = 9'h100
    } field_e;

    typedef struct packed
    {
        logic valid;
        logic [7:0] octet;
    } octet_s;

    typedef struct packed
    {
        field_e field;
        logic [2:0] headIdx;
    } tag_s;

endpackage

// ### hdl/octet_walker.sv
// walker that tracks where one octet sits inside a length-prefixed group
// assumes octets are presented one per cycle with a valid flag
module octet_walker
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire itab_pkg::octet_s inOctet,
    output itab_pkg::tag_s tag,
    output logic [15:0] declaredLen,
    output logic [15:0] bodyCount,
    output logic done,
    output logic lenError
);
    itab_pkg::field_e field;
    logic [7:0] remain;
    logic [7:0] domRemain;
    logic [2:0] headIdx;
    logic [7:0] oct;
    logic take;
    logic inBody;
    logic [15:0] nextCount;

    assign oct = inOctet.octet;
    assign take = inOctet.valid && field != itab_pkg::P_DONE;
    assign inBody = field != itab_pkg::P_LENHI && field != itab_pkg::P_LENLO;
    assign nextCount = bodyCount + 16'h0001;
    assign tag = '{field: field, headIdx: headIdx};

    always_ff @(posedge clock)
    begin
        if (rst || start)
        begin
            field <= itab_pkg::P_LENHI;
            remain <= itab_pkg::OCTET_RESET;
            domRemain <= itab_pkg::OCTET_RESET;
            headIdx <= 3'h0;
            declaredLen <= itab_pkg::LEN_RESET;
            bodyCount <= itab_pkg::LEN_RESET;
            done <= 1'b0;
            lenError <= 1'b0;
        end
        else if (take)
        begin
            if (inBody)
            begin
                bodyCount <= nextCount;
                if (nextCount > declaredLen)
                begin
                    lenError <= 1'b1;
                end
            end
            case (field)
                itab_pkg::P_LENHI:
                begin
                    declaredLen[15:8] <= oct;
                    field <= itab_pkg::P_LENLO;
                end
                itab_pkg::P_LENLO:
                begin
                    declaredLen[7:0] <= oct;
                    field <= itab_pkg::P_NODECNT;
                end
                itab_pkg::P_NODECNT:
                begin
                    remain <= oct;
                    field <= (oct == 8'h00) ? itab_pkg::P_DOMCNT : itab_pkg::P_NODES;
                end
                itab_pkg::P_NODES:
                begin
                    remain <= remain - 8'h01;
                    if (remain == 8'h01)
                    begin
                        field <= itab_pkg::P_DOMCNT;
                    end
                end
                itab_pkg::P_DOMCNT:
                begin
                    domRemain <= oct;
                    headIdx <= 3'h0;
                    field <= (oct == 8'h00) ? itab_pkg::P_SCOPE : itab_pkg::P_DOMHEAD;
                end
                itab_pkg::P_DOMHEAD:
                begin
                    headIdx <= headIdx + 3'h1;
                    if (headIdx == 3'(itab_pkg::ENTRY_HEAD_OCTETS - 1))
                    begin
                        remain <= oct;
                        headIdx <= 3'h0;
                        if (oct != 8'h00)
                        begin
                            field <= itab_pkg::P_IFNODES;
                        end
                        else
                        begin
                            domRemain <= domRemain - 8'h01;
                            field <= (domRemain == 8'h01) ? itab_pkg::P_SCOPE
                                                          : itab_pkg::P_DOMHEAD;
                        end
                    end
                end
                itab_pkg::P_IFNODES:
                begin
                    remain <= remain - 8'h01;
                    if (remain == 8'h01)
                    begin
                        domRemain <= domRemain - 8'h01;
                        field <= (domRemain == 8'h01) ? itab_pkg::P_SCOPE
                                                      : itab_pkg::P_DOMHEAD;
                    end
                end
                itab_pkg::P_SCOPE:
                begin
                    field <= itab_pkg::P_DONE;
                    done <= 1'b1;
                    if (nextCount != declaredLen)
                    begin
                        lenError <= 1'b1;
                    end
                end
                default:
                begin
                    field <= itab_pkg::P_DONE;
                end
            endcase
        end
    end
endmodule

// ### tb/itab_peer.sv
// peer node model: sinks framed octets, sources octets to the parser
// expects the codec's valid/ready octet link on the shared clock
module itab_peer
(
    input wire logic clock,
    input wire logic rst,
    input wire logic txValid,
    input wire logic [7:0] txOctet,
    output logic txReady = 1'b0,
    input wire logic rxReady,
    output logic rxValid = 1'b0,
    output logic [7:0] rxOctet = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txQ [$];
    logic [7:0] rxQ [$];
    logic slow = 1'b0;
    // --------
    // link
    // --------
    always @(posedge clock)
    begin
        if (txValid && txReady)
            txQ.push_back(txOctet);
        if (rxValid && rxReady)
            void'(rxQ.pop_front());
        // slow mode is ready only every other cycle
        txReady <= !rst && !(slow && txReady);
        rxValid <= !rst && rxQ.size() > 0;
        // idle data toggles so a stale octet never looks valid
        rxOctet <= (rxQ.size() > 0) ? rxQ[0] : ~rxOctet;
    end
endmodule

// ### tb/itab_assertions.sv
// checker for the group codec: bus answer and octet link timing
// bound to interference_table_codec, sees its ports only
module itab_assertions
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic txValid,
    input wire logic [7:0] txOctet,
    input wire logic txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire hit = wb_adr_i[31:8] == 24'h0 && wb_adr_i[1:0] == 2'b00
        && wb_adr_i[7:0] <= itab_pkg::TXSCOPE_ADDR;
    // --------
    // properties
    // --------
    chk_ack_once:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_answer_next:
        assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
    chk_mapped_ack:
        assert property (req && hit |=> wb_ack_o) else $error("mapped access not acked");
    chk_unmapped_err:
        assert property (req && !hit |=> wb_err_o) else $error("unmapped access not refused");
    chk_no_spurious:
        assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    chk_tx_hold:
        assert property (txValid && !txReady |=> txValid && $stable(txOctet))
        else $error("tx octet dropped or changed while stalled");
    chk_rx_one_held:
        assert property (rxValid && rxReady |=> !rxReady) else $error("second rx octet taken");
    chk_reset_quiet:
        assert property ($fell(rst) |-> !txValid && !rxReady && !wb_ack_o)
        else $error("outputs active out of reset");
    cover property (txValid && txReady);
    cover property (rxValid && rxReady);
    cover property (req && !hit);
endmodule

bind interference_table_codec itab_assertions itab_assertions_i (.clock(clock), .rst(rst),
    .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .rxValid(rxValid), .rxReady(rxReady), .txValid(txValid),
    .txOctet(txOctet), .txReady(txReady));

// ### tb/testbench.sv
// top bench: Wishbone tasks, framer and parser group scenarios
// drives interference_table_codec with itab_peer on the octet link
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic rxValid;
    logic [7:0] rxOctet;
    logic rxReady;
    logic txValid;
    logic [7:0] txOctet;
    logic txReady;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;
    logic [7:0] grp [18] = '{8'h00, 8'h11, 8'h02, 8'hA1, 8'hA2, 8'h02, 8'h12, 8'h34, 8'h56,
        8'h01, 8'h00, 8'h65, 8'h43, 8'h21, 8'h02, 8'h02, 8'hB1, 8'hB2};
    always #2.5 clock = ~clock;
    interference_table_codec interference_table_codec_i (.clock(clock), .rst(rst),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .rxValid(rxValid),
        .rxOctet(rxOctet), .rxReady(rxReady), .txValid(txValid), .txOctet(txOctet),
        .txReady(txReady));
    itab_peer itab_peer_i (.clock(clock), .rst(rst), .txValid(txValid), .txOctet(txOctet),
        .txReady(txReady), .rxReady(rxReady), .rxValid(rxValid), .rxOctet(rxOctet));
    // --------
    // tasks
    // --------
    task automatic close_out();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= {24'h000000, a};
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clock);
        while (ack !== 1'b1 && err !== 1'b1)
            @(posedge clock);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic txPut(input logic [7:0] o);
        q = 32'h1;
        while (q[0] !== 1'b0)
            bus(itab_pkg::STATUS_ADDR, 1'b0, 32'h0);
        bus(itab_pkg::TXDATA_ADDR, 1'b1, {24'h000000, o});
    endtask
    task automatic rxGroup(input logic [15:0] len, input logic [7:0] sc, input logic [31:0] st);
        logic [7:0] ex [19];
        bus(itab_pkg::CTRL_ADDR, 1'b1, 32'h2);
        ex = '{default: 8'h00};
        foreach (grp[i])
            ex[i] = grp[i];
        ex[0] = len[15:8];
        ex[1] = len[7:0];
        ex[18] = sc;
        foreach (ex[i])
            itab_peer_i.rxQ.push_back(ex[i]);
        for (int i = 0; i < 19; i++)
        begin
            q = 32'h0;
            while (q[4] !== 1'b1)
                bus(itab_pkg::STATUS_ADDR, 1'b0, 32'h0);
            bus(itab_pkg::RXDATA_ADDR, 1'b0, 32'h0);
            chk({23'h0, q[11], q[7:0]}, {23'h0, i == 18, ex[i]});
            chk({29'h0, q[10:8]}, {29'h0, (i >= 6 && i < 16) ? 3'((i - 6) % 5) : 3'h0});
        end
        bus(itab_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(q & 32'h000000E0, st);
        bus(itab_pkg::RXINFO_ADDR, 1'b0, 32'h0);
        chk(q, {len, 16'h0011});
        bus(itab_pkg::TXSCOPE_ADDR, 1'b0, 32'h0);
        chk(q, {30'h0, sc[1:0]});
    endtask
    // --------
    // sequence
    // --------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("Error at %0t: timeout", $time);
            close_out();
        end
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(itab_pkg::STATUS_ADDR, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(itab_pkg::RXINFO_ADDR, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(8'h40, 1'b0, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int s = 0; s < 2; s++)
        begin
            itab_peer_i.txQ.delete();
            itab_peer_i.slow = (s == 0);
            bus(itab_pkg::CTRL_ADDR, 1'b1, 32'h1);
            bus(itab_pkg::TXSCOPE_ADDR, 1'b1, (s == 0) ? 32'hFD : 32'h02);
            foreach (grp[i])
                txPut(grp[i]);
            repeat (20) @(posedge clock);
            chk(itab_peer_i.txQ.size(), 32'd19);
            for (int i = 0; i < 18; i++)
                chk({24'h0, itab_peer_i.txQ[i]}, {24'h0, grp[i]});
            chk({24'h0, itab_peer_i.txQ[18]}, (s == 0) ? 32'h03 : 32'h00);
            bus(itab_pkg::STATUS_ADDR, 1'b0, 32'h0);
            chk(q & 32'h0000000C, 32'h4);
        end
        rxGroup(16'h0011, 8'hFF, 32'h20);
        rxGroup(16'h0012, 8'h01, 32'hE0);
        close_out();
    end
endmodule
